// ===== include/fpe_pkg.sv
// fpe_pkg: constants, register layout and state types for the flash program/erase controller
// assumes a 100 MHz APB clock and byte-wide flash addressing within a 64 KB space
package fpe_pkg;

    // ----------------------------------------------------------------
    // address map
    // ----------------------------------------------------------------
    localparam logic [15:0] FPE_USER_LO = 16'hE000;
    localparam logic [15:0] FPE_USER_HI = 16'hFDFF;
    localparam logic [15:0] FPE_CTRL_ADDR = 16'hFE08;
    localparam logic [15:0] FPE_BPR_ADDR = 16'hFF7E;
    localparam logic [15:0] FPE_VEC_LO = 16'hFFD2;
    localparam logic [15:0] FPE_VEC_HI = 16'hFFFF;
    localparam int FPE_USER_BYTES = 7680;
    localparam int FPE_VEC_BYTES = 46;
    localparam int FPE_PAGE_BYTES = 64;
    localparam int FPE_ROW_BYTES = 32;

    // ----------------------------------------------------------------
    // apb register byte addresses (offsets as printed)
    // ----------------------------------------------------------------
    localparam logic [15:0] FPE_STATUS_ADDR = 16'hFE0C;
    localparam logic [15:0] FPE_SECURE_ADDR = 16'hFE10;

    // ----------------------------------------------------------------
    // control register fields and reset value
    // ----------------------------------------------------------------
    localparam int FPE_PGM_BIT = 0;
    localparam int FPE_ERASE_BIT = 1;
    localparam int FPE_MASS_BIT = 2;
    localparam int FPE_HIGH_VOLTAGE_ENABLE_BIT = 3;
    localparam logic [3:0] FPE_CTRL_RESET = 4'h0;
    localparam logic [7:0] FPE_BPR_RESET = 8'hFF;
    localparam logic [7:0] FPE_ERASED_BYTE = 8'hFF;

    // ----------------------------------------------------------------
    // timing: nonvolatile_setup_time, 10 us minimum
    // ----------------------------------------------------------------
    localparam int FPE_CLK_MHZ = 100;
    localparam int FPE_NVS_US = 10;
    localparam int FPE_NVS_CYC = FPE_NVS_US * FPE_CLK_MHZ;

    // sequence state of the flash controller
    typedef enum logic [2:0] {
        FPE_IDLE,
        FPE_ARMED,
        FPE_LATCHED,
        FPE_HV_ON
    } fpe_state_t;

endpackage

// ===== rtl/fpe_timer.sv
// fpe_timer: setup-time counter started by the latching write
// assumes a single pclk domain; start is a one-cycle pulse
`timescale 1ns/1ps
module fpe_timer #(
    parameter int CYCLES = 1000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic clear,
    output logic done
);
    import fpe_pkg::*;

    logic [15:0] cnt_reg;

    // ----------------------------------------------------------------
    // count down after start, done when expired
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 16'h0000;
            done <= 1'b0;
        end else if (clear) begin
            cnt_reg <= 16'h0000;
            done <= 1'b0;
        end else if (start) begin
            cnt_reg <= 16'(CYCLES);
            done <= 1'b0;
        end else if (cnt_reg != 16'h0000) begin
            cnt_reg <= cnt_reg - 16'h0001;
            done <= (cnt_reg == 16'h0001);
        end
    end
endmodule

// ===== rtl/fpe_protect.sv
// fpe_protect: decodes the block protect byte into a protected range test
// assumes addresses are 16-bit flash byte addresses
`timescale 1ns/1ps
module fpe_protect (
    input wire logic [7:0] bpr,
    input wire logic [15:0] addr,
    input wire logic mass,
    output logic locked
);
    import fpe_pkg::*;

    logic [15:0] start_addr;

    // ----------------------------------------------------------------
    // start = {11, bpr, 000000}; 0xFF leaves everything open
    // ----------------------------------------------------------------
    always_comb begin
        start_addr = {2'b11, bpr, 6'b000000};
        if (bpr == FPE_BPR_RESET) begin
            locked = 1'b0;
        end else if (mass) begin
            locked = 1'b1; // whole array overlaps the range
        end else begin
            locked = (addr >= start_addr);
        end
    end
endmodule

// ===== rtl/fpe_ctrl.sv
// fpe_ctrl: program/erase control of a byte-wide flash array behind APB
// assumes APB byte addresses equal flash addresses; array is flops
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module fpe_ctrl #(
    parameter int NVS_CYCLES = fpe_pkg::FPE_NVS_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic secure,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic pump_on,
    output logic hv_to_array
);
    import fpe_pkg::*;

    localparam int NBYTES = FPE_USER_BYTES + FPE_VEC_BYTES;

    logic [7:0] mem_reg [NBYTES];
    logic [7:0] bpr_reg;
    logic [3:0] ctrl_reg;
    logic [3:0] ctrl_next;
    logic [15:0] lat_addr_reg;
    logic bpr_read_reg;
    fpe_state_t state_reg;
    logic setup_done;
    logic locked;
    logic [15:0] a16;
    logic wr_acc;
    logic rd_acc;
    logic is_user;
    logic is_vec;
    logic is_flash;
    logic in_range;

    // index of a user or vector byte
    function automatic int unsigned flash_index(input logic [15:0] a);
        if (a <= FPE_USER_HI) begin
            flash_index = 32'(a - FPE_USER_LO);
        end else begin
            flash_index = 32'(a - FPE_VEC_LO) + FPE_USER_BYTES;
        end
    endfunction

    // page number (address bits 15:6) of an array index; vectors sit above the user bytes
    function automatic logic [9:0] index_page(input int unsigned i);
        logic [15:0] a;
        if (i < FPE_USER_BYTES) begin
            a = FPE_USER_LO + 16'(i);
        end else begin
            a = FPE_VEC_LO + 16'(i - FPE_USER_BYTES);
        end
        index_page = a[15:6];
    endfunction

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    assign a16 = paddr[15:0];
    assign in_range = (paddr[31:16] == 16'h0000);
    assign is_user = in_range && a16 >= FPE_USER_LO && a16 <= FPE_USER_HI;
    assign is_vec = in_range && a16 >= FPE_VEC_LO;
    assign is_flash = is_user || is_vec || (in_range && a16 == FPE_BPR_ADDR);
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;

    fpe_timer #(
        .CYCLES(NVS_CYCLES)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(wr_acc && is_flash && state_reg == FPE_ARMED && bpr_read_reg),
        .clear(state_reg == FPE_IDLE),
        .done(setup_done)
    );

    fpe_protect u_protect (
        .bpr(bpr_reg),
        .addr(lat_addr_reg),
        .mass(ctrl_reg[FPE_MASS_BIT]),
        .locked(locked)
    );

    // ----------------------------------------------------------------
    // control register next value with interlocks
    // ----------------------------------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_acc && in_range && a16 == FPE_CTRL_ADDR) begin
            ctrl_next[FPE_MASS_BIT] = pwdata[FPE_MASS_BIT];
            // erase and program mutually exclusive; a request for both is dropped
            if (!(pwdata[FPE_PGM_BIT] && pwdata[FPE_ERASE_BIT])) begin
                ctrl_next[FPE_PGM_BIT] = pwdata[FPE_PGM_BIT] && !ctrl_reg[FPE_ERASE_BIT];
                ctrl_next[FPE_ERASE_BIT] = pwdata[FPE_ERASE_BIT] && !ctrl_reg[FPE_PGM_BIT];
            end
            // high_voltage_enable set accepted only after setup and with the range unprotected
            if (pwdata[FPE_HIGH_VOLTAGE_ENABLE_BIT] && !ctrl_reg[FPE_HIGH_VOLTAGE_ENABLE_BIT]) begin
                ctrl_next[FPE_HIGH_VOLTAGE_ENABLE_BIT] = (ctrl_reg[FPE_PGM_BIT] || ctrl_reg[FPE_ERASE_BIT])
                    && state_reg == FPE_LATCHED && setup_done && !locked;
            end else begin
                ctrl_next[FPE_HIGH_VOLTAGE_ENABLE_BIT] = pwdata[FPE_HIGH_VOLTAGE_ENABLE_BIT];
            end
        end
    end

    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= FPE_CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // ----------------------------------------------------------------
    // sequence tracking: select, protect read, latching write, hv
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= FPE_IDLE;
            bpr_read_reg <= 1'b0;
            lat_addr_reg <= 16'h0000;
        end else begin
            case (state_reg)
                FPE_IDLE: begin
                    bpr_read_reg <= 1'b0;
                    if (ctrl_next[FPE_PGM_BIT] || ctrl_next[FPE_ERASE_BIT]) begin
                        state_reg <= FPE_ARMED;
                    end
                end
                FPE_ARMED: begin
                    if (rd_acc && in_range && a16 == FPE_BPR_ADDR) begin
                        bpr_read_reg <= 1'b1;
                    end
                    if (wr_acc && is_flash && bpr_read_reg) begin
                        lat_addr_reg <= a16;
                        state_reg <= FPE_LATCHED;
                    end
                end
                FPE_LATCHED: begin
                    if (ctrl_next[FPE_HIGH_VOLTAGE_ENABLE_BIT]) begin
                        state_reg <= FPE_HV_ON;
                    end
                end
                FPE_HV_ON: begin
                    if (!ctrl_next[FPE_HIGH_VOLTAGE_ENABLE_BIT]) begin
                        state_reg <= FPE_IDLE;
                    end
                end
                default: begin
                    state_reg <= FPE_IDLE;
                end
            endcase
            if (!ctrl_next[FPE_PGM_BIT] && !ctrl_next[FPE_ERASE_BIT]
                && !ctrl_next[FPE_HIGH_VOLTAGE_ENABLE_BIT]) begin
                state_reg <= FPE_IDLE;
            end
        end
    end

    // ----------------------------------------------------------------
    // array: erase to ones, program clears bits (and-in), 32-byte rows
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NBYTES; i++) begin
                mem_reg[i] <= FPE_ERASED_BYTE;
            end
            bpr_reg <= FPE_BPR_RESET;
        end else if (state_reg == FPE_HV_ON && ctrl_reg[FPE_ERASE_BIT]
                     && !ctrl_next[FPE_ERASE_BIT]) begin
            // erase lands when the erase select is dropped under high voltage
            for (int i = 0; i < NBYTES; i++) begin
                if (ctrl_reg[FPE_MASS_BIT]) begin
                    mem_reg[i] <= FPE_ERASED_BYTE;
                end else if (index_page(i) == lat_addr_reg[15:6]) begin
                    mem_reg[i] <= FPE_ERASED_BYTE;
                end
            end
            if (ctrl_reg[FPE_MASS_BIT] || lat_addr_reg[15:6] == FPE_BPR_ADDR[15:6]) begin
                bpr_reg <= FPE_ERASED_BYTE;
            end
        end else if (state_reg == FPE_HV_ON && ctrl_reg[FPE_PGM_BIT] && wr_acc && is_flash
                     && a16[15:5] == lat_addr_reg[15:5] && !locked) begin
            // program only within the latched row, bits can only go to zero
            if (a16 == FPE_BPR_ADDR) begin
                bpr_reg <= bpr_reg & pwdata[7:0];
            end else begin
                mem_reg[flash_index(a16)] <= mem_reg[flash_index(a16)] & pwdata[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // apb outputs, zero-wait answer registered
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !(is_flash
                || (in_range && (a16 == FPE_CTRL_ADDR || a16 == FPE_STATUS_ADDR)));
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                if (in_range && a16 == FPE_CTRL_ADDR) begin
                    prdata <= {28'h0000000, ctrl_reg};
                end else if (in_range && a16 == FPE_STATUS_ADDR) begin
                    prdata <= {27'h0000000, locked, setup_done, 3'(state_reg)};
                end else if (in_range && a16 == FPE_BPR_ADDR) begin
                    prdata <= {24'h000000, bpr_reg};
                end else if (is_flash) begin
                    // secure mode blanks the array to outside readers
                    prdata <= secure ? 32'h0000_0000
                        : {24'h000000, mem_reg[flash_index(a16)]};
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // charge pump and array high voltage follow the hv bit
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pump_on <= 1'b0;
            hv_to_array <= 1'b0;
        end else begin
            pump_on <= ctrl_next[FPE_HIGH_VOLTAGE_ENABLE_BIT];
            hv_to_array <= ctrl_next[FPE_HIGH_VOLTAGE_ENABLE_BIT];
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    interlock_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(ctrl_reg[FPE_PGM_BIT] && ctrl_reg[FPE_ERASE_BIT]))
        else $error("program and erase both set");
    hv_needs_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(ctrl_reg[FPE_HIGH_VOLTAGE_ENABLE_BIT]) |-> $past(ctrl_reg[FPE_PGM_BIT] || ctrl_reg[FPE_ERASE_BIT]))
        else $error("hv set without select");
    hv_protect_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(ctrl_reg[FPE_HIGH_VOLTAGE_ENABLE_BIT]) |-> !$past(locked))
        else $error("hv set in protected range");
    pump_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        pump_on == ctrl_reg[FPE_HIGH_VOLTAGE_ENABLE_BIT] && hv_to_array == pump_on)
        else $error("pump does not follow hv bit");
    upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready && !pwrite && a16 == FPE_CTRL_ADDR |-> prdata[31:4] == 28'h0000000)
        else $error("control upper bits nonzero");
    secure_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready && secure && !pwrite && (is_user || is_vec) |-> prdata == 32'h0000_0000)
        else $error("secure read leaked data");
    apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready ##1 !pready)
        else $error("apb answer not one cycle");
    hv_after_setup_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(ctrl_reg[FPE_HIGH_VOLTAGE_ENABLE_BIT]) |-> $past(setup_done) && $past(state_reg) == FPE_LATCHED)
        else $error("hv before setup");
    hv_state_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_reg[FPE_HIGH_VOLTAGE_ENABLE_BIT] == (state_reg == FPE_HV_ON))
        else $error("hv bit and sequence state disagree");
    err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error without ready");
    erase_lands_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(ctrl_reg[FPE_ERASE_BIT]) && $past(state_reg) == FPE_HV_ON
            && lat_addr_reg != FPE_BPR_ADDR
            |-> mem_reg[flash_index(lat_addr_reg)] == FPE_ERASED_BYTE)
        else $error("erase left latched byte programmed");
    hv_cov_c: cover property (@(posedge pclk) $rose(ctrl_reg[FPE_HIGH_VOLTAGE_ENABLE_BIT]));
    mass_cov_c: cover property (@(posedge pclk)
        state_reg == FPE_HV_ON && ctrl_reg[FPE_MASS_BIT] && $fell(ctrl_reg[FPE_ERASE_BIT]));
    refuse_cov_c: cover property (@(posedge pclk)
        wr_acc && a16 == FPE_CTRL_ADDR && pwdata[FPE_HIGH_VOLTAGE_ENABLE_BIT] && !ctrl_next[FPE_HIGH_VOLTAGE_ENABLE_BIT]);
    erase_cov_c: cover property (@(posedge pclk)
        state_reg == FPE_HV_ON && $fell(ctrl_reg[FPE_ERASE_BIT]));
    prog_cov_c: cover property (@(posedge pclk) state_reg == FPE_HV_ON && wr_acc);
endmodule

// ===== bench/testbench.sv
// testbench: random and corner-case checks of the flash program/erase controller
// assumes fpe_pkg is compiled first; the bench drives the APB and pin inputs itself
`timescale 1ns/1ps
module testbench;
    import fpe_pkg::*;

    // ----------------------------------------------------------------
    // signals and bench state
    // ----------------------------------------------------------------
    localparam int NVS = 5;
    logic pclk, presetn, psel, penable, pwrite, secure;
    logic [31:0] paddr, pwdata, prdata;
    logic pready, pslverr, pump_on, hv_to_array;
    int miscompares, tests_run;
    logic [31:0] seed = 32'h1CA7;
    logic [7:0] model [int];
    logic [31:0] rdv;
    logic errv;
    logic [15:0] base_a, base_b;

    fpe_ctrl #(.NVS_CYCLES(NVS)) u_fpe_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .secure(secure),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pump_on(pump_on),
        .hv_to_array(hv_to_array));

    // free-running 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // xorshift source, fixed start
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // expected byte: unwritten cells read erased
    function automatic logic [7:0] mexp(input int a);
        return model.exists(a) ? model[a] : FPE_ERASED_BYTE;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
        int n;
        logic [31:0] r;
        r = xs();
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {16'h0000, a};
        pwdata <= {r[31:8], d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            miscompares++;
            $display("[ERR] %0t no pready", $time);
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rdv, {24'h000000, exp});
    endtask

    // select, protect read, latching write, setup wait, then high voltage request
    task automatic arm(input logic [7:0] c, input logic [15:0] a);
        wr(FPE_CTRL_ADDR, c);
        apb(1'b0, FPE_BPR_ADDR, 8'h00);
        wr(a, 8'hFF);
        repeat (NVS + 3) @(posedge pclk);
        wr(FPE_CTRL_ADDR, c | 8'h08);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 32'h0; pwdata = 32'h0; secure = 1'b0;
        miscompares = 0; tests_run = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(FPE_CTRL_ADDR, 8'h00);
        rdc(FPE_BPR_ADDR, 8'hFF);
        rdc(FPE_USER_LO, 8'hFF);
        chk(32'(errv), 32'h0);
        rdc(FPE_VEC_HI, 8'hFF);
        chk(32'(pump_on), 32'h0);
        apb(1'b0, 16'hFE20, 8'h00);
        chk(32'(errv), 32'h1);
        wr(16'hFE20, 8'h5A);
        chk(32'(errv), 32'h1);
        // field layout and select interlock
        wr(FPE_CTRL_ADDR, 8'hF4);
        rdc(FPE_CTRL_ADDR, 8'h04);
        wr(FPE_CTRL_ADDR, 8'h00);
        wr(FPE_CTRL_ADDR, 8'h03);
        rdc(FPE_CTRL_ADDR, 8'h00);
        wr(FPE_CTRL_ADDR, 8'h02);
        wr(FPE_CTRL_ADDR, 8'h03);
        rdc(FPE_CTRL_ADDR, 8'h02);
        wr(FPE_CTRL_ADDR, 8'h0A);
        rdc(FPE_CTRL_ADDR, 8'h02);
        wr(FPE_CTRL_ADDR, 8'h00);
        // high voltage refused when the protect read was skipped
        wr(FPE_CTRL_ADDR, 8'h02);
        wr(FPE_USER_LO, 8'hFF);
        repeat (NVS + 3) @(posedge pclk);
        wr(FPE_CTRL_ADDR, 8'h0A);
        rdc(FPE_CTRL_ADDR, 8'h02);
        wr(FPE_CTRL_ADDR, 8'h00);
        // program one row in each of two different random pages
        base_a = FPE_USER_LO + 16'((xs() % 120) * 64);
        base_b = FPE_USER_LO + 16'((((base_a - FPE_USER_LO) / 64 + 1 + xs() % 119) % 120) * 64 + 32);
        for (int k = 0; k < 2; k++) begin
            logic [15:0] b;
            logic [7:0] d;
            b = (k == 0) ? base_a : base_b;
            arm(8'h01, b + 16'(xs() % 32));
            rdc(FPE_CTRL_ADDR, 8'h09);
            repeat (2) @(posedge pclk);
            chk(32'(pump_on), 32'h1);
            chk(32'(hv_to_array), 32'h1);
            for (int i = 0; i < 32; i++) begin
                d = 8'(xs());
                wr(b + 16'(i), d);
                repeat (3) @(posedge pclk);
                model[int'(b) + i] = mexp(int'(b) + i) & d;
            end
            wr(FPE_CTRL_ADDR, 8'h08);
            wr(FPE_CTRL_ADDR, 8'h00);
            repeat (2) @(posedge pclk);
            chk(32'(pump_on), 32'h0);
            chk(32'(hv_to_array), 32'h0);
        end
        foreach (model[k]) rdc(16'(k), model[k]);
        // secure mode hides array data only
        secure <= 1'b1;
        rdc(base_a, 8'h00);
        rdc(FPE_BPR_ADDR, 8'hFF);
        secure <= 1'b0;
        // page erase of the first page leaves the other page alone
        arm(8'h02, base_a + 16'h0005);
        rdc(FPE_CTRL_ADDR, 8'h0A);
        wr(FPE_CTRL_ADDR, 8'h08);
        repeat (NVS) @(posedge pclk);
        wr(FPE_CTRL_ADDR, 8'h00);
        repeat (2) @(posedge pclk);
        for (int i = 0; i < 64; i++) model.delete(int'(base_a) + i);
        for (int i = 0; i < 64; i++) rdc(base_a + 16'(i), 8'hFF);
        foreach (model[k]) rdc(16'(k), model[k]);
        // mass erase clears everything
        arm(8'h06, base_a);
        rdc(FPE_CTRL_ADDR, 8'h0E);
        wr(FPE_CTRL_ADDR, 8'h0C);
        repeat (NVS) @(posedge pclk);
        wr(FPE_CTRL_ADDR, 8'h00);
        foreach (model[k]) rdc(16'(k), 8'hFF);
        model.delete();
        // a vector byte sits in the top page and is page-erasable too
        arm(8'h01, FPE_VEC_HI);
        wr(FPE_VEC_HI, 8'h3C);
        wr(FPE_CTRL_ADDR, 8'h08);
        wr(FPE_CTRL_ADDR, 8'h00);
        rdc(FPE_VEC_HI, 8'h3C);
        arm(8'h02, FPE_VEC_LO);
        wr(FPE_CTRL_ADDR, 8'h08);
        wr(FPE_CTRL_ADDR, 8'h00);
        rdc(FPE_VEC_HI, 8'hFF);
        // program the protect byte, then expect refusals
        arm(8'h01, FPE_BPR_ADDR);
        wr(FPE_BPR_ADDR, 8'h80);
        wr(FPE_CTRL_ADDR, 8'h08);
        wr(FPE_CTRL_ADDR, 8'h00);
        rdc(FPE_BPR_ADDR, 8'h80);
        arm(8'h01, FPE_USER_LO);
        rdc(FPE_CTRL_ADDR, 8'h01);
        rdc(FPE_STATUS_ADDR, 8'h1A);
        chk(32'(pump_on), 32'h0);
        wr(FPE_USER_LO, 8'h00);
        rdc(FPE_USER_LO, 8'hFF);
        wr(FPE_CTRL_ADDR, 8'h00);
        arm(8'h06, FPE_USER_LO + 16'h0040);
        rdc(FPE_CTRL_ADDR, 8'h06);
        wr(FPE_CTRL_ADDR, 8'h00);
        // second reset in mid-run
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(FPE_CTRL_ADDR, 8'h00);
        rdc(FPE_BPR_ADDR, 8'hFF);
        final_report();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        $display("[ERR] %0t watchdog expired", $time);
        final_report();
    end
endmodule
